// ---- rtl/hsq_defs.vh ----
// Purpose: Shared constants of the haptic sequencer register port
// Assumes: Included by every design file of the block
// Notes: Definitions only
`ifndef HSQ_DEFS_VH
`define HSQ_DEFS_VH

// Bus identity and byte framing
`define HSQ_DEV_ADDR 7'h59
`define HSQ_BYTE_BITS 4'h8

// Register offsets
`define HSQ_REG_CTRL 8'h02
`define HSQ_REG_SLOT_FIRST 8'h03
`define HSQ_REG_SLOT_SECOND 8'h04
`define HSQ_REG_SLOT_LAST 8'h0a

// Control register fields
`define HSQ_CTRL_LAUNCH 0

// Queue geometry and reset values
`define HSQ_NUM_SLOTS 8
`define HSQ_SLOT_AW 3
`define HSQ_SLOT_RESET 8'h00
`define HSQ_ID_END 8'h00

`endif

// ---- rtl/hsq_slot_mem.v ----
// Purpose: Eight-entry queue of waveform identifiers
// Assumes: One write port, two independent read ports
// Notes: Read data come out of registers, one cycle after the address
`timescale 1ns/10ps
`include "hsq_defs.vh"

module hsq_slot_mem #(
   parameter W = 8,
   parameter D = `HSQ_NUM_SLOTS,
   parameter AW = `HSQ_SLOT_AW
) (
   input wire i_clk,
   input wire i_rst,
   input wire i_we,
   input wire [AW-1:0] i_wa,
   input wire [W-1:0] i_wd,
   input wire [AW-1:0] i_ra_a,
   output reg [W-1:0] o_rd_a,
   input wire [AW-1:0] i_ra_b,
   output reg [W-1:0] o_rd_b
);

   reg [W-1:0] mem [0:D-1];
   integer i;

   always @(posedge i_clk) begin
      if (i_rst) begin
         for (i = 0; i < D; i = i + 1) begin
            mem[i] <= `HSQ_SLOT_RESET;
         end
         o_rd_a <= `HSQ_SLOT_RESET;
         o_rd_b <= `HSQ_SLOT_RESET;
      end else begin
         if (i_we) begin
            mem[i_wa] <= i_wd;
         end
         o_rd_a <= mem[i_ra_a];
         o_rd_b <= mem[i_ra_b];
      end
   end

endmodule // hsq_slot_mem

// ---- rtl/hsq_top.v ----
// Purpose: Two-wire slave register port and waveform sequencer
// Assumes: SCL and SDA come from pins; playback engine on the same clock
// Notes: SDA is open drain, driven low only while O_SDA_OE is high
//
// Contract
// [R1] Queue holds at most eight waveform identifiers
// [R2] Launch starts playback at slot offset 0x03
// [R3] After each waveform, advance to next slot
// [R4] Stop at zero identifier or after eight
// [R5] Identifier is the header block index
// [R6] Bytes are eight bits, MSB first
// [R7] Receiver acknowledges in the following clock period
// [R8] Master frames transfers with start and stop
// [R9] Data changes only while SCL is low
// [R10] Slave acknowledge holds SDA low whole period
// [R11] Slave answers only bus address 0x59
// [R12] Unlimited bytes between start and stop
// [R13] Single and multi-byte access to every register
// [R14] Register address auto-increments after each data byte
// [R15] Write: address, register byte, data, stop
// [R16] Slave acknowledges address, register and data bytes
// [R17] Read: write address, repeated start, read
// [R18] Master ends a read with not-acknowledge, stop
// [R19] Master acknowledges all read bytes but last
// [R20] Master waits for acknowledge before next byte
// [R21] Unmatched address: no acknowledge, ignore until start
`timescale 1ns/10ps
`include "hsq_defs.vh"

module hsq_top (
   input wire I_CLK_SYS,
   input wire I_RST,
   input wire I_SCL,
   input wire I_SDA,
   output reg O_SDA_OUT,
   output reg O_SDA_OE,
   output reg [7:0] O_WAVE_ID,
   output reg O_WAVE_START,
   input wire I_WAVE_DONE,
   output reg O_SEQ_BUSY
);

   // Bus states
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_DEV = 3'h1;
   localparam [2:0] ST_REG = 3'h2;
   localparam [2:0] ST_WDATA = 3'h3;
   localparam [2:0] ST_RDATA = 3'h4;
   localparam [2:0] ST_ACKTX = 3'h5;
   localparam [2:0] ST_ACKRX = 3'h6;

   // Sequencer states
   localparam [1:0] SQ_IDLE = 2'h0;
   localparam [1:0] SQ_FETCH = 2'h1;
   localparam [1:0] SQ_CHECK = 2'h2;
   localparam [1:0] SQ_PLAY = 2'h3;

   localparam integer LAST_SLOT_I = `HSQ_NUM_SLOTS - 1;
   localparam [2:0] LAST_SLOT = LAST_SLOT_I[2:0];

   function is_slot;
      input [7:0] a;
      begin
         is_slot = (a >= `HSQ_REG_SLOT_FIRST) && (a <= `HSQ_REG_SLOT_LAST);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and bus event detection

   reg scl_s1_r, scl_s2_r, scl_d_r;
   reg sda_s1_r, sda_s2_r, sda_d_r;

   always @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         scl_s1_r <= 1'b1;
         scl_s2_r <= 1'b1;
         scl_d_r <= 1'b1;
         sda_s1_r <= 1'b1;
         sda_s2_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_s1_r <= I_SCL;
         scl_s2_r <= scl_s1_r;
         scl_d_r <= scl_s2_r;
         sda_s1_r <= I_SDA;
         sda_s2_r <= sda_s1_r;
         sda_d_r <= sda_s2_r;
      end
   end

   wire scl_rise = scl_s2_r & ~scl_d_r;
   wire scl_fall = ~scl_s2_r & scl_d_r;
   // SDA edges while SCL stays high frame a transfer
   wire bus_start = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r; // [R8]
   wire bus_stop = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r; // [R8]

   ////////////////////////////////////////////////////////////////////////////
   // Register read path

   reg [7:0] ptr_r;
   wire [7:0] slot_off = ptr_r - `HSQ_REG_SLOT_FIRST;
   wire [7:0] mem_rd_a;
   wire [7:0] mem_rd_b;
   reg [7:0] rd_byte;

   always @* begin
      if (is_slot(ptr_r)) begin // [R13]
         rd_byte = mem_rd_a;
      end else if (ptr_r == `HSQ_REG_CTRL) begin
         rd_byte = {7'h00, O_SEQ_BUSY};
      end else begin
         rd_byte = 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serial slave engine

   reg [2:0] st_r;
   reg [2:0] after_r;
   reg [3:0] cnt_r;
   reg [7:0] shift_r;
   reg incr_r;
   reg mack_r;
   reg mem_we_r;
   reg [2:0] mem_wa_r;
   reg [7:0] mem_wd_r;
   reg launch_r;

   always @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         st_r <= ST_IDLE;
         after_r <= ST_IDLE;
         cnt_r <= 4'h0;
         shift_r <= 8'h00;
         ptr_r <= 8'h00;
         incr_r <= 1'b0;
         mack_r <= 1'b0;
         mem_we_r <= 1'b0;
         mem_wa_r <= 3'h0;
         mem_wd_r <= 8'h00;
         launch_r <= 1'b0;
         O_SDA_OUT <= 1'b0;
         O_SDA_OE <= 1'b0;
      end else begin
         mem_we_r <= 1'b0;
         launch_r <= 1'b0;
         O_SDA_OUT <= 1'b0;
         if (bus_start) begin
            // Also a repeated start; pointer is kept
            st_r <= ST_DEV; // [R21]
            cnt_r <= 4'h0;
            incr_r <= 1'b0;
            O_SDA_OE <= 1'b0;
         end else if (bus_stop) begin
            st_r <= ST_IDLE;
            O_SDA_OE <= 1'b0;
         end else if (scl_rise) begin
            case (st_r)
               ST_DEV, ST_REG, ST_WDATA: begin
                  shift_r <= {shift_r[6:0], sda_s2_r}; // [R6]
                  cnt_r <= cnt_r + 4'h1;
               end
               ST_RDATA: begin
                  cnt_r <= cnt_r + 4'h1;
               end
               ST_ACKRX: begin
                  mack_r <= ~sda_s2_r; // [R19]
               end
               default: begin
               end
            endcase
         end else if (scl_fall) begin
            case (st_r)
               ST_DEV: begin
                  if (cnt_r == `HSQ_BYTE_BITS) begin
                     if (shift_r[7:1] == `HSQ_DEV_ADDR) begin // [R11]
                        O_SDA_OE <= 1'b1; // [R16]
                        after_r <= shift_r[0] ? ST_RDATA : ST_REG; // [R17]
                        st_r <= ST_ACKTX;
                     end else begin
                        st_r <= ST_IDLE; // [R21]
                     end
                  end
               end
               ST_REG: begin
                  if (cnt_r == `HSQ_BYTE_BITS) begin
                     ptr_r <= shift_r; // [R14]
                     O_SDA_OE <= 1'b1; // [R16]
                     after_r <= ST_WDATA;
                     st_r <= ST_ACKTX;
                  end
               end
               ST_WDATA: begin
                  if (cnt_r == `HSQ_BYTE_BITS) begin
                     mem_we_r <= is_slot(ptr_r); // [R13]
                     mem_wa_r <= slot_off[2:0];
                     mem_wd_r <= shift_r;
                     launch_r <= (ptr_r == `HSQ_REG_CTRL) && shift_r[`HSQ_CTRL_LAUNCH];
                     incr_r <= 1'b1;
                     O_SDA_OE <= 1'b1; // [R16] [R7]
                     after_r <= ST_WDATA; // [R12]
                     st_r <= ST_ACKTX;
                  end
               end
               ST_ACKTX: begin
                  // Ack held from one SCL fall to the next
                  cnt_r <= 4'h0; // [R10]
                  incr_r <= 1'b0;
                  if (incr_r) begin
                     ptr_r <= ptr_r + 8'h01; // [R14]
                  end
                  if (after_r == ST_RDATA) begin
                     shift_r <= rd_byte;
                     O_SDA_OE <= ~rd_byte[7]; // [R9]
                  end else begin
                     O_SDA_OE <= 1'b0;
                  end
                  st_r <= after_r;
               end
               ST_RDATA: begin
                  if (cnt_r == `HSQ_BYTE_BITS) begin
                     O_SDA_OE <= 1'b0; // [R7]
                     ptr_r <= ptr_r + 8'h01; // [R14]
                     st_r <= ST_ACKRX;
                  end else begin
                     shift_r <= {shift_r[6:0], 1'b0}; // [R6]
                     O_SDA_OE <= ~shift_r[6]; // [R9]
                  end
               end
               ST_ACKRX: begin
                  cnt_r <= 4'h0;
                  if (mack_r) begin
                     shift_r <= rd_byte; // [R19]
                     O_SDA_OE <= ~rd_byte[7];
                     st_r <= ST_RDATA;
                  end else begin
                     O_SDA_OE <= 1'b0; // [R18]
                     st_r <= ST_IDLE;
                  end
               end
               default: begin
                  O_SDA_OE <= 1'b0;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Waveform sequencer

   reg [1:0] sq_r;
   reg [2:0] idx_r;

   hsq_slot_mem #(
      .W(8),
      .D(`HSQ_NUM_SLOTS),
      .AW(`HSQ_SLOT_AW)
   ) hsq_slot_mem_i (
      .i_clk(I_CLK_SYS),
      .i_rst(I_RST),
      .i_we(mem_we_r),
      .i_wa(mem_wa_r),
      .i_wd(mem_wd_r),
      .i_ra_a(slot_off[2:0]),
      .o_rd_a(mem_rd_a),
      .i_ra_b(idx_r),
      .o_rd_b(mem_rd_b)
   ); // [R1]

   always @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         sq_r <= SQ_IDLE;
         idx_r <= 3'h0;
         O_WAVE_ID <= 8'h00;
         O_WAVE_START <= 1'b0;
         O_SEQ_BUSY <= 1'b0;
      end else begin
         O_WAVE_START <= 1'b0;
         case (sq_r)
            SQ_IDLE: begin
               if (launch_r) begin
                  idx_r <= 3'h0; // [R2]
                  O_SEQ_BUSY <= 1'b1;
                  sq_r <= SQ_FETCH;
               end
            end
            SQ_FETCH: begin
               // Slot read data settle into the port register
               sq_r <= SQ_CHECK;
            end
            SQ_CHECK: begin
               if (mem_rd_b == `HSQ_ID_END) begin
                  O_SEQ_BUSY <= 1'b0; // [R4]
                  sq_r <= SQ_IDLE;
               end else begin
                  O_WAVE_ID <= mem_rd_b; // [R5]
                  O_WAVE_START <= 1'b1;
                  sq_r <= SQ_PLAY;
               end
            end
            SQ_PLAY: begin
               if (I_WAVE_DONE) begin
                  if (idx_r == LAST_SLOT) begin
                     O_SEQ_BUSY <= 1'b0; // [R4]
                     sq_r <= SQ_IDLE;
                  end else begin
                     idx_r <= idx_r + 3'h1; // [R3]
                     sq_r <= SQ_FETCH;
                  end
               end
            end
            default: begin
               sq_r <= SQ_IDLE;
            end
         endcase
      end
   end

endmodule // hsq_top

// ---- dv/hsq_top_properties.sv ----
// Purpose: Port-level checks of the register port and sequencer
// Assumes: Bound to hsq_top; one clock domain
// Notes: None
`timescale 1ns/10ps
module hsq_top_properties (
   input wire I_CLK_SYS,
   input wire I_RST,
   input wire I_SCL,
   input wire I_SDA,
   input wire O_SDA_OUT,
   input wire O_SDA_OE,
   input wire [7:0] O_WAVE_ID,
   input wire O_WAVE_START,
   input wire I_WAVE_DONE,
   input wire O_SEQ_BUSY
);
   default clocking cb @(posedge I_CLK_SYS);
   endclocking
   default disable iff (I_RST);
   AST_SDA_ZERO: assert property (O_SDA_OUT == 1'b0)
      else $error("sda data value not low");
   AST_ACK_WHOLE: assert property ($rose(O_SDA_OE) |-> O_SDA_OE [*8])
      else $error("sda pull released early");
   AST_SDA_SCL_LOW: assert property ($changed(O_SDA_OE) |-> !I_SCL)
      else $error("sda changed while scl high");
   AST_LAUNCH_PLAY: assert property ($rose(O_SEQ_BUSY) |-> ##2 (O_WAVE_START || !O_SEQ_BUSY))
      else $error("launch not followed by play");
   AST_START_BUSY: assert property (O_WAVE_START |-> O_SEQ_BUSY)
      else $error("start outside busy");
   AST_START_PULSE: assert property (O_WAVE_START |=> !O_WAVE_START)
      else $error("start longer than one cycle");
   AST_START_NONZERO: assert property (O_WAVE_START |-> O_WAVE_ID != 8'h00)
      else $error("zero identifier played");
   AST_ID_HOLD: assert property (!O_WAVE_START |-> $stable(O_WAVE_ID))
      else $error("identifier changed without start");
   AST_DONE_NEXT: assert property (O_SEQ_BUSY && I_WAVE_DONE |-> ##[1:3] (O_WAVE_START || !O_SEQ_BUSY))
      else $error("no next step after done");
endmodule // hsq_top_properties

// ---- dv/hsq_i2c_master_model.sv ----
// Purpose: Two-wire bus master driving the slave port
// Assumes: SDA resolved outside with a pull-up
// Notes: Phases of 8 system clocks
`timescale 1ns/10ps
module hsq_i2c_master_model (
   input wire i_clk,
   input wire i_sda,
   output reg o_scl,
   output reg o_sda_low
);
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   task automatic ph;
      repeat (8) @(negedge i_clk);
   endtask
   task automatic start;
      o_sda_low = 1'b0;
      ph;
      o_scl = 1'b1;
      ph;
      o_sda_low = 1'b1;
      ph;
      o_scl = 1'b0;
   endtask
   task automatic stop;
      @(negedge i_clk);
      o_sda_low = 1'b1;
      ph;
      o_scl = 1'b1;
      ph;
      o_sda_low = 1'b0;
      ph;
   endtask
   task automatic bitx(input logic b, output logic r);
      @(negedge i_clk);
      o_sda_low = !b;
      ph;
      o_scl = 1'b1;
      ph;
      r = i_sda;
      o_scl = 1'b0;
   endtask
   // Byte MSB first, then the acknowledge slot
   task automatic xfer(input logic [7:0] d, input logic n, output logic [7:0] q, output logic a);
      for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
      bitx(n, a);
      a = !a;
   endtask
endmodule // hsq_i2c_master_model

// ---- dv/hsq_top_tb.sv ----
// Purpose: Self-checking bench of the register port and sequencer
// Assumes: Master model on the bus, wave engine modelled here
// Notes: None
`timescale 1ns/10ps
module hsq_top_tb;
   logic clk;
   logic rst = 1'b1;
   logic done = 1'b0;
   wire scl, mst_low, sda_oe, sda_out, start_w, busy;
   wire [7:0] wave_id;
   wire sda = !(mst_low || (sda_oe && !sda_out));
   int miscompares = 0, n_checks = 0, cnt = 0;
   logic [7:0] dat [0:8];
   logic [7:0] ids [0:7] = '{8'h05, 8'h06, 8'h07, 8'h00, 8'h09, 8'h0a, 8'h0b, 8'h0c};
   logic [7:0] played [$];
   logic [7:0] q;
   logic a;
   hsq_top hsq_top_i (.I_CLK_SYS(clk), .I_RST(rst), .I_SCL(scl), .I_SDA(sda), .O_SDA_OUT(sda_out),
      .O_SDA_OE(sda_oe), .O_WAVE_ID(wave_id), .O_WAVE_START(start_w), .I_WAVE_DONE(done), .O_SEQ_BUSY(busy));
   hsq_i2c_master_model mst (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(mst_low));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Playback engine: each waveform lasts 40 cycles
   always @(negedge clk) begin
      done = (cnt == 1);
      if (cnt > 0) cnt--;
      if (start_w === 1'b1) begin
         played.push_back(wave_id);
         cnt = 40;
      end
   end
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic head(input logic [7:0] r);
      mst.start;
      mst.xfer(8'hb2, 1'b1, q, a);
      chk("addr ack", 8'h01, {7'h0, a});
      mst.xfer(r, 1'b1, q, a);
      chk("reg ack", 8'h01, {7'h0, a});
   endtask
   task automatic wr(input logic [7:0] r, input int n);
      head(r);
      for (int i = 0; i < n; i++) begin
         mst.xfer(dat[i], 1'b1, q, a);
         chk("data ack", 8'h01, {7'h0, a});
      end
      mst.stop;
   endtask
   task automatic rd(input logic [7:0] r, input int n);
      head(r);
      mst.start;
      mst.xfer(8'hb3, 1'b1, q, a);
      chk("read ack", 8'h01, {7'h0, a});
      for (int i = 0; i < n; i++) mst.xfer(8'hff, i == n - 1, dat[i], a);
      mst.stop;
   endtask
   task automatic play(input int n);
      played.delete();
      dat[0] = 8'h01;
      wr(8'h02, 1);
      chk("busy after launch", 8'h01, {7'h0, busy});
      for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(negedge clk);
      chk("played count", n[7:0], played.size());
      for (int i = 0; i < n; i++) chk("played id", ids[i], played[i]);
      chk("last id held", ids[n - 1], wave_id);
   endtask
   task automatic end_of_test;
      if (miscompares == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // About three times the expected run of some 9000 cycles
   initial begin
      #600000;
      miscompares++;
      end_of_test;
   end
   initial begin
      repeat (5) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      rd(8'h03, 8);
      for (int i = 0; i < 8; i++) chk("reset slot", 8'h00, dat[i]);
      mst.start;
      mst.xfer(8'hb4, 1'b1, q, a);
      chk("foreign addr ack", 8'h00, {7'h0, a});
      mst.xfer(8'h03, 1'b1, q, a);
      chk("ignored byte ack", 8'h00, {7'h0, a});
      mst.stop;
      for (int i = 0; i < 8; i++) dat[i] = ids[i];
      wr(8'h03, 8);
      rd(8'h03, 9);
      for (int i = 0; i < 8; i++) chk("slot", ids[i], dat[i]);
      chk("unmapped", 8'h00, dat[8]);
      rd(8'h05, 1);
      chk("single read", 8'h07, dat[0]);
      play(3);
      ids[3] = 8'h08;
      dat[0] = 8'h08;
      wr(8'h06, 1);
      play(8);
      rd(8'h02, 1);
      chk("idle status", 8'h00, dat[0]);
      end_of_test;
   end
endmodule // hsq_top_tb

bind hsq_top hsq_top_properties hsq_top_properties_i (.I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_SCL(I_SCL),
   .I_SDA(I_SDA), .O_SDA_OUT(O_SDA_OUT), .O_SDA_OE(O_SDA_OE), .O_WAVE_ID(O_WAVE_ID),
   .O_WAVE_START(O_WAVE_START), .I_WAVE_DONE(I_WAVE_DONE), .O_SEQ_BUSY(O_SEQ_BUSY));
